// >>> hdl/fsp_ctrl.sv
// Register access over AHB-Lite and the address map were decided locally.
module fsp_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // fuses and signature row, same clock domain
    input wire logic no_boot_section,
    input wire logic self_program_fuse,
    input wire logic [7:0] fuse_byte,
    input wire logic [7:0] sig_row_data,
    output logic [4:0] sig_row_addr,
    input wire logic chip_erase,
    // flash array side
    input wire logic flash_done,
    output fsp_pkg::fsp_flash_req_s flash_req,
    input wire logic [5:0] buf_rd_index,
    output logic [15:0] buf_rd_data,
    // status
    output logic section_busy_flag,
    output fsp_pkg::fsp_lock_s lock_status
);
    import fsp_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    fsp_state_s s_reg;
    fsp_state_s s_next;

    logic [4:0] low_bits;
    logic pat_ok;
    logic store_allowed;
    logic [7:0] page;
    logic [5:0] word;
    logic [7:0] load_byte;

    assign low_bits = hwdata[4:0];
    assign page = s_reg.zptr[14:7];
    assign word = s_reg.zptr[6:1];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.req.erase = 1'b0;
        s_next.req.write = 1'b0;
        s_next.resp = 1'b0;

        // only these patterns may arm a command
        pat_ok = (low_bits == PAT_RRE) || (low_bits == PAT_LCK) ||
                 (low_bits == PAT_PGW) || (low_bits == PAT_PGE) ||
                 (low_bits == PAT_EN);

        // no boot section: the fuse must be programmed (low)
        store_allowed = !no_boot_section || !self_program_fuse;

        // store and load windows run down one count per core cycle
        if (s_reg.phase == FSP_ARMED) begin
            if (s_reg.st_win != 3'h0) begin
                s_next.st_win = s_reg.st_win - 3'h1;
            end
            if (s_reg.ld_win != 2'h0) begin
                s_next.ld_win = s_reg.ld_win - 2'h1;
            end
            if (s_reg.st_win == 3'h1) begin
                // window lapsed unused: drop command and enable
                s_next.phase = FSP_IDLE;
                s_next.cmd = CTRL_RST[5:1];
                s_next.en = 1'b0;
            end
        end

        // erase or write finished in the array
        if (s_reg.phase == FSP_BUSY && flash_done) begin
            s_next.phase = FSP_IDLE;
            s_next.en = 1'b0;
            s_next.cmd = CTRL_RST[5:1];
            s_next.stall = 1'b0;
            if (s_reg.cmd[PGW_BIT]) begin
                // the buffer is spent once written to a page
                s_next.valid = '0;
            end
        end

        // ********************************************************
        // data phase
        // ********************************************************
        if (s_reg.dp_wr) begin
            s_next.dp_wr = 1'b0;
            case (s_reg.dp_idx)
                CMD_IDX: begin
                    // while an operation runs every command is refused
                    if (s_reg.phase != FSP_BUSY && pat_ok) begin
                        s_next.phase = FSP_ARMED;
                        s_next.en = 1'b1;
                        s_next.cmd[4:1] = low_bits[4:1];
                        s_next.cmd[SIG_BIT] = hwdata[SIG_BIT] &&
                                              (low_bits == PAT_EN);
                        s_next.st_win = STORE_WIN;
                        s_next.ld_win = LOAD_WIN;
                        if (low_bits == PAT_RRE) begin
                            s_next.valid = '0;
                        end
                    end
                end
                DATA_IDX: begin
                    s_next.data = hwdata[15:0];
                end
                PTR_IDX: begin
                    s_next.zptr = hwdata[15:0];
                end
                STORE_IDX: begin
                    if (s_reg.phase == FSP_ARMED) begin
                        // window used: close it whatever happens
                        s_next.phase = FSP_IDLE;
                        s_next.cmd = CTRL_RST[5:1];
                        s_next.en = 1'b0;
                        s_next.st_win = 3'h0;
                        s_next.ld_win = 2'h0;
                        if (!store_allowed) begin
                            s_next.en = 1'b0;
                        end else if (s_reg.cmd[SIG_BIT]) begin
                            s_next.en = 1'b0;
                        end else if (s_reg.cmd[RRE_BIT]) begin
                            s_next.busy = 1'b0;
                        end else if (s_reg.cmd[LCK_BIT]) begin
                            // bits only go 1 to 0; top two stay 1
                            s_next.lock = s_reg.lock &
                                {2'b11, s_reg.data[5:0]};
                        end else if (s_reg.cmd[PGW_BIT] ||
                                     s_reg.cmd[PGE_BIT]) begin
                            s_next.phase = FSP_BUSY;
                            s_next.en = 1'b1;
                            s_next.cmd = s_reg.cmd;
                            s_next.req.write = s_reg.cmd[PGW_BIT];
                            s_next.req.erase = s_reg.cmd[PGE_BIT];
                            s_next.req.page = page;
                            if (page < STALLING_FLASH_SECTION_FIRST_PAGE) begin
                                s_next.busy = 1'b1;
                            end else begin
                                // hold off the next transfer until done
                                s_next.stall = 1'b1;
                            end
                        end else begin
                            s_next.words[word] = s_reg.data;
                            s_next.valid[word] = 1'b1;
                            s_next.busy = 1'b0;
                        end
                    end
                end
                default: begin
                    // lock and load bytes are read-only here, others unmapped
                    s_next.dp_wr = 1'b0;
                end
            endcase
        end

        // apart from sys_rst, only chip erase brings programmed lock bits back to 1
        if (chip_erase) begin
            s_next.lock = LOCK_RST;
        end

        // ********************************************************
        // load result
        // ********************************************************
        load_byte = 8'h00;
        if (s_reg.phase == FSP_ARMED && s_reg.ld_win != 2'h0) begin
            if (s_reg.cmd[SIG_BIT]) begin
                load_byte = sig_row_data;
            end else if (s_reg.cmd[LCK_BIT]) begin
                load_byte = s_reg.zptr[0] ? s_reg.lock
                                          : fuse_byte;
            end
        end

        // ********************************************************
        // address phase
        // ********************************************************
        if (hsel && htrans[1] && hready) begin
            s_next.dp_wr = hwrite;
            s_next.dp_idx = haddr[9:2];
            // reads other than the load byte see the value after any write in flight
            case (haddr[9:2])
                CMD_IDX: begin
                    s_next.rdata = {24'h0, 1'b0, s_next.busy,
                                    s_next.cmd, s_next.en};
                end
                LOCK_IDX: begin
                    s_next.rdata = {24'h0, s_next.lock};
                end
                DATA_IDX: begin
                    s_next.rdata = {16'h0, s_next.data};
                end
                PTR_IDX: begin
                    s_next.rdata = {16'h0, s_next.zptr};
                end
                LOAD_IDX: begin
                    s_next.rdata = {24'h0, load_byte};
                end
                default: begin
                    s_next.rdata = 32'h0;
                end
            endcase
        end

        s_next.ready = !s_next.stall;

        // ********************************************************
        // status outputs
        // ********************************************************
        s_next.brd = s_next.valid[buf_rd_index] ?
                     s_next.words[buf_rd_index] : ERASED_WORD;
        s_next.lk.ext_prog_block = !s_next.lock[0];
        s_next.lk.fuse_locked = !s_next.lock[0];
        s_next.lk.ext_verify_block = s_next.lock[1:0] == 2'b00;
        s_next.lk.boot_lock_locked = s_next.lock[1:0] == 2'b00;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= FSP_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hrdata = s_reg.rdata;
    assign hreadyout = s_reg.ready;
    assign hresp = s_reg.resp;
    assign sig_row_addr = s_reg.zptr[5:1];
    assign flash_req = s_reg.req;
    assign buf_rd_data = s_reg.brd;
    // the array must refuse shared-section access on this level
    assign section_busy_flag = s_reg.busy;
    assign lock_status = s_reg.lk;

endmodule // fsp_ctrl

// >>> shared/fsp_pkg.sv
package fsp_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] CMD_IDX = 8'h37;
    localparam logic [7:0] LOCK_IDX = 8'h38;
    localparam logic [7:0] DATA_IDX = 8'h39;
    localparam logic [7:0] PTR_IDX = 8'h3A;
    localparam logic [7:0] STORE_IDX = 8'h3B;
    localparam logic [7:0] LOAD_IDX = 8'h3C;

    // control register bit positions
    localparam int BUSY_BIT = 6;
    localparam int SIG_BIT = 5;
    localparam int RRE_BIT = 4;
    localparam int LCK_BIT = 3;
    localparam int PGW_BIT = 2;
    localparam int PGE_BIT = 1;

    // accepted low five bit patterns
    localparam logic [4:0] PAT_RRE = 5'h11;
    localparam logic [4:0] PAT_LCK = 5'h09;
    localparam logic [4:0] PAT_PGW = 5'h05;
    localparam logic [4:0] PAT_PGE = 5'h03;
    localparam logic [4:0] PAT_EN = 5'h01;

    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [1:0] LOAD_WIN = 2'h3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] STALLING_FLASH_SECTION_FIRST_PAGE = 8'hE0;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_BUSY
    } fsp_phase_e;

    typedef struct packed {
        logic erase;
        logic write;
        logic [7:0] page;
    } fsp_flash_req_s;

    typedef struct packed {
        logic ext_prog_block;
        logic ext_verify_block;
        logic fuse_locked;
        logic boot_lock_locked;
    } fsp_lock_s;

    typedef struct packed {
        fsp_phase_e phase;
        logic [5:1] cmd;
        logic en;
        logic busy;
        logic [2:0] st_win;
        logic [1:0] ld_win;
        logic stall;
        logic dp_wr;
        logic [7:0] dp_idx;
        logic [15:0] data;
        logic [15:0] zptr;
        logic [7:0] lock;
        logic [63:0] valid;
        logic [63:0][15:0] words;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        fsp_flash_req_s req;
        logic [15:0] brd;
        fsp_lock_s lk;
    } fsp_state_s;

    localparam fsp_state_s FSP_STATE_RST = '{
        phase: FSP_IDLE,
        cmd: CTRL_RST[5:1],
        en: CTRL_RST[0],
        lock: LOCK_RST,
        ready: 1'b1,
        brd: ERASED_WORD,
        default: '0
    };

endpackage

// >>> tb/fsp_ctrl_sva.sv
module fsp_ctrl_sva
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // watched ports
    input wire logic hreadyout,
    input wire logic chip_erase,
    input wire logic flash_done,
    input wire fsp_pkg::fsp_flash_req_s flash_req,
    input wire logic section_busy_flag,
    input wire fsp_pkg::fsp_lock_s lock_status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // flash operation and lock checks
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_op;
        flash_req.erase || flash_req.write;
    endsequence
    sequence s_stalling_flash_section_op;
        s_op ##0 flash_req.page >= STALLING_FLASH_SECTION_FIRST_PAGE;
    endsequence
    sequence s_rww_op;
        s_op ##0 flash_req.page < STALLING_FLASH_SECTION_FIRST_PAGE;
    endsequence
    a_stall_stalling_flash_section: assert property (s_stalling_flash_section_op |-> !hreadyout)
        else $error("stalling section op without stall");
    a_stall_hold: assert property (!hreadyout && !flash_done |=>
        !hreadyout)
        else $error("stall ended before array done");
    a_stall_end: assert property (!hreadyout && flash_done |=>
        hreadyout)
        else $error("stall kept after array done");
    a_rww_free: assert property (s_rww_op |-> hreadyout)
        else $error("shared section op stalled the core");
    a_busy_set: assert property (s_rww_op |-> section_busy_flag)
        else $error("busy flag not set by shared section op");
    a_busy_cause: assert property ($rose(section_busy_flag) |->
        s_rww_op)
        else $error("busy flag rose without an op");
    a_req_pulse: assert property (s_op |=>
        !flash_req.erase && !flash_req.write)
        else $error("flash request longer than one cycle");
    a_lock_clear: assert property (chip_erase [*3] |->
        lock_status == '0)
        else $error("chip erase left protection active");
    a_mode_three: assert property (lock_status.ext_verify_block |->
        lock_status.ext_prog_block && lock_status.boot_lock_locked)
        else $error("verify block without full lock");
    a_mode_two: assert property (lock_status.ext_prog_block |->
        lock_status.fuse_locked)
        else $error("programming block without fuse lock");
endmodule // fsp_ctrl_sva

bind fsp_ctrl fsp_ctrl_sva u_sva (.ref_clk, .sys_rst, .hreadyout,
    .chip_erase, .flash_done, .flash_req, .section_busy_flag, .lock_status);

// >>> tb/fsp_ctrl_tb.sv
module fsp_ctrl_tb;
    import fsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, flash_done, section_busy_flag;
    logic no_boot_section = 1'b0;
    logic self_program_fuse = 1'b0;
    logic chip_erase = 1'b0;
    logic [5:0] buf_rd_index = 6'h0;
    logic [4:0] sig_row_addr;
    logic [15:0] buf_rd_data;
    fsp_flash_req_s flash_req;
    fsp_lock_s lock_status;
    int miscompares = 0;
    int tests_run = 0;
    int ops = 0;
    int lows = 0;
    int n0;
    fsp_ctrl dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .no_boot_section, .self_program_fuse, .fuse_byte(8'h5A),
        .sig_row_data(8'hA5), .sig_row_addr, .chip_erase, .flash_done,
        .flash_req, .buf_rd_index, .buf_rd_data, .section_busy_flag,
        .lock_status);
    fsp_flash_model #(.LAT(12)) u_flash (.ref_clk, .sys_rst, .flash_req,
        .flash_done);
    // ****************************************
    // bus helpers and scenarios
    // ****************************************
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // sampled mid-cycle so registered outputs have settled
    always @(negedge ref_clk) begin
        if (flash_req.erase || flash_req.write) ops++;
        if (hreadyout !== 1'b1) lows++;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // hready is judged on the falling edge: the value the next rise samples
    task automatic rdy;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 500) begin
                miscompares++;
                conclude();
            end
            @(negedge ref_clk);
        end
    endtask
    // entered just after a rising edge, left on the edge ending the data phase
    task automatic xfer(input logic [7:0] i, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        rdy();
        @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        xfer(i, 1'b1, d);
    endtask
    task automatic rc(input logic [7:0] i, input logic [31:0] e);
        xfer(i, 1'b0, 32'h0);
        chk(rd, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic st;
        xfer(STORE_IDX, 1'b1, 32'h0);
    endtask
    task automatic bchk(input logic [5:0] i, input logic [15:0] e);
        @(posedge ref_clk);
        buf_rd_index <= i;
        repeat (2) @(negedge ref_clk);
        chk({16'h0, buf_rd_data}, {16'h0, e});
        @(posedge ref_clk);
    endtask
    task automatic t_window;
        logic [7:0] p [3] = '{8'h05, 8'h03, 8'h09};
        rc(CMD_IDX, 32'h0);
        rc(LOCK_IDX, 32'hFF);
        rc(8'h20, 32'h0);
        wr(CMD_IDX, 32'h07);
        rc(CMD_IDX, 32'h0);
        wr(CMD_IDX, 32'h41);
        rc(CMD_IDX, 32'h01);
        rc(CMD_IDX, 32'h01);
        rc(CMD_IDX, 32'h0);
        foreach (p[k]) begin
            wr(CMD_IDX, {24'h0, p[k]});
            repeat (5) @(posedge ref_clk);
            rc(CMD_IDX, 32'h0);
            n0 = ops;
            st();
            chk(32'(ops - n0), 32'h0);
        end
        $display("test window done");
    endtask
    task automatic t_buffer;
        wr(DATA_IDX, 32'h1234);
        wr(PTR_IDX, 32'h0007);
        wr(CMD_IDX, 32'h01);
        st();
        rc(CMD_IDX, 32'h0);
        bchk(6'h3, 16'h1234);
        no_boot_section <= 1'b1;
        self_program_fuse <= 1'b1;
        wr(PTR_IDX, 32'h0008);
        wr(CMD_IDX, 32'h01);
        st();
        bchk(6'h4, 16'hFFFF);
        self_program_fuse <= 1'b0;
        wr(CMD_IDX, 32'h01);
        st();
        bchk(6'h4, 16'h1234);
        no_boot_section <= 1'b0;
        wr(CMD_IDX, 32'h11);
        st();
        bchk(6'h3, 16'hFFFF);
        wr(PTR_IDX, 32'h0003);
        wr(CMD_IDX, 32'h21);
        rc(LOAD_IDX, 32'hA5);
        chk({27'h0, sig_row_addr}, 32'h1);
        wr(CMD_IDX, 32'h21);
        st();
        bchk(6'h1, 16'hFFFF);
        $display("test buffer done");
    endtask
    task automatic t_flash;
        wr(PTR_IDX, 32'h0800);
        wr(CMD_IDX, 32'h05);
        n0 = ops;
        st();
        rc(CMD_IDX, 32'h45);
        chk({31'h0, section_busy_flag}, 32'h1);
        wr(CMD_IDX, 32'h11);
        st();
        chk({31'h0, section_busy_flag}, 32'h1);
        repeat (16) @(posedge ref_clk);
        chk(32'(ops - n0), 32'h1);
        chk({24'h0, flash_req.page}, 32'h10);
        rc(CMD_IDX, 32'h40);
        wr(CMD_IDX, 32'h11);
        st();
        rc(CMD_IDX, 32'h0);
        wr(CMD_IDX, 32'h03);
        st();
        repeat (16) @(posedge ref_clk);
        wr(CMD_IDX, 32'h01);
        st();
        @(negedge ref_clk);
        chk({31'h0, section_busy_flag}, 32'h0);
        @(posedge ref_clk);
        wr(PTR_IDX, 32'h7000);
        wr(CMD_IDX, 32'h03);
        n0 = lows;
        st();
        // this read waits out the stall before its address is taken
        rc(CMD_IDX, 32'h0);
        chk(32'(lows - n0 >= 12), 32'h1);
        chk({24'h0, flash_req.page}, 32'hE0);
        chk({31'h0, section_busy_flag}, 32'h0);
        $display("test flash done");
    endtask
    task automatic t_lock;
        wr(DATA_IDX, 32'hAA3E);
        wr(CMD_IDX, 32'h09);
        st();
        rc(LOCK_IDX, 32'hFE);
        chk({28'h0, lock_status}, 32'hA);
        wr(DATA_IDX, 32'h3F);
        wr(CMD_IDX, 32'h09);
        st();
        rc(LOCK_IDX, 32'hFE);
        wr(DATA_IDX, 32'h3C);
        wr(CMD_IDX, 32'h09);
        st();
        rc(CMD_IDX, 32'h0);
        rc(LOCK_IDX, 32'hFC);
        chk({28'h0, lock_status}, 32'hF);
        wr(PTR_IDX, 32'h1);
        wr(CMD_IDX, 32'h09);
        rc(LOAD_IDX, 32'hFC);
        wr(PTR_IDX, 32'h0);
        wr(CMD_IDX, 32'h09);
        rc(LOAD_IDX, 32'h5A);
        chip_erase <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chip_erase <= 1'b0;
        rc(LOCK_IDX, 32'hFF);
        chk({28'h0, lock_status}, 32'h0);
        $display("test lock done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_window();
        t_buffer();
        t_flash();
        t_lock();
        conclude();
    end
endmodule // fsp_ctrl_tb

// >>> tb/fsp_flash_model.sv
module fsp_flash_model
    import fsp_pkg::*;
#(parameter int LAT = 12) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // array request and completion
    input wire fsp_pkg::fsp_flash_req_s flash_req,
    output logic flash_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // slow enough that requests can be issued while the array still works
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_req.erase || flash_req.write) begin
                cnt <= LAT;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // fsp_flash_model
